// [verilog/brg_defs.svh]
// Constants for the bus reset generator: state codes and reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef BRG_DEFS_SVH
`define BRG_DEFS_SVH

// State register width and codes; bit 0 is the released reset level
`define BRG_STATE_W 3
`define BRG_ST_HOLD 3'h0
`define BRG_ST_INIT1 3'h2
`define BRG_ST_INIT2 3'h4
`define BRG_STATE_RUNNING 3'h1

// Bit of the state register that drives the reset output
`define BRG_OUT_BIT 0

// Default number of added initialisation cycles, largest allowed count
`define BRG_EXTRA_INIT_DEF 0
`define BRG_EXTRA_INIT_MAX 255

// Cycles the output stays low in the two init states with no added cycles
`define BRG_BASE_INIT 2

// Reset value of the clock-valid synchroniser
`define BRG_CV_RST 1'h0

`endif

// [verilog/brg_pkg.sv]
// Types shared by the bus reset generator.
// Assumes brg_defs.svh is on the include path.
`default_nettype none
`include "brg_defs.svh"

package brg_pkg;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   // Codes are fixed so that bit 0 is low in every holding state
   typedef enum logic [`BRG_STATE_W-1:0] {
      state_power_on_hold = `BRG_ST_HOLD,
      state_init_first = `BRG_ST_INIT1,
      state_init_second = `BRG_ST_INIT2,
      state_running = `BRG_STATE_RUNNING
   } brg_state_t;

   // Synchronised inputs as seen by the sequencer
   typedef struct packed {
      logic por_high;
      logic clk_valid;
   } brg_sync_t;

endpackage : brg_pkg

`default_nettype wire

// [verilog/brg_bus_reset_gen.sv]
// Bus reset generator: makes the active-low bus reset from the
// asynchronous active-low power-on reset input.
// Assumes clk is the bus clock and that the power-on source keeps its
// input low until the clock and supply are stable.
//
// Notes on behaviour
// - Accept asynchronous active-low power-on reset input
// - Output falls at once when input falls
// - Output rises only on rising clock edge
// - Only power-on reset input asserts output
// - Input registered once before machine uses it
// - Four states, all rising-edge clocked
// - Hold state entered and kept while low
// - Leave hold on second edge input high
// - Stay in hold until clock valid
// - First init holds low, always goes second
// - Second init holds low, always goes run
// - Run drives high until input falls
// - Two cycles default, parameter adds more
// - Output is state bit 0 AND input
// - Output falls even with clock stopped
`default_nettype none
`include "brg_defs.svh"

module brg_bus_reset_gen
   import brg_pkg::*;
#(
   parameter int EXTRA_INIT = `BRG_EXTRA_INIT_DEF
) (
   // Clock and house reset
   input wire logic clk,
   input wire logic rst,
   // Power-on side
   input wire logic power_on_reset_in_n,
   input wire logic clock_valid_in,
   // Bus side
   output logic bus_reset_out_n
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   localparam int CNT_W = (EXTRA_INIT > 0) ? $clog2(EXTRA_INIT + 1) : 1;
   // Cycles from the first init state to the run state
   localparam int INIT_LEN = `BRG_BASE_INIT + EXTRA_INIT;

   if (EXTRA_INIT < 0 || EXTRA_INIT > `BRG_EXTRA_INIT_MAX) begin : g_chk
      $error("EXTRA_INIT out of range");
   end

   brg_state_t state_ff;
   brg_state_t nxt_state;
   brg_sync_t sync;
   logic por_sync_ff;
   logic cv_meta_ff;
   logic cv_sync_ff;
   logic [CNT_W-1:0] extra_cnt_ff;
   logic extra_done;

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   // Single rising-edge register on the power-on input
   always_ff @(posedge clk) begin
      por_sync_ff <= power_on_reset_in_n;
   end

   // Two-stage synchroniser for the clock-valid level
   always_ff @(posedge clk) begin
      if (rst) begin
         cv_meta_ff <= `BRG_CV_RST;
         cv_sync_ff <= `BRG_CV_RST;
      end else begin
         cv_meta_ff <= clock_valid_in;
         cv_sync_ff <= cv_meta_ff;
      end
   end

   assign sync.por_high = por_sync_ff;
   assign sync.clk_valid = cv_sync_ff;

   // ----------------------------------------------------------------
   // Reset sequencer
   // ----------------------------------------------------------------
   // Counts added cycles in the second init state
   always_ff @(posedge clk) begin
      if (state_ff != state_init_second) begin
         extra_cnt_ff <= '0;
      end else if (!extra_done) begin
         extra_cnt_ff <= extra_cnt_ff + 1'b1;
      end
   end

   assign extra_done = (EXTRA_INIT == 0) ||
                       (extra_cnt_ff == CNT_W'(EXTRA_INIT));

   // Next-state decode
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         state_power_on_hold: begin
            if (sync.por_high && sync.clk_valid) begin
               nxt_state = state_init_first;
            end
         end
         state_init_first: begin
            nxt_state = state_init_second;
         end
         state_init_second: begin
            if (extra_done) begin
               nxt_state = state_running;
            end
         end
         state_running: begin
            if (!sync.por_high) begin
               nxt_state = state_power_on_hold;
            end
         end
         default: begin
            nxt_state = state_power_on_hold;
         end
      endcase
   end

   // State register; the raw input clears it without a clock edge
   always_ff @(posedge clk or negedge power_on_reset_in_n) begin
      if (!power_on_reset_in_n) begin
         state_ff <= state_power_on_hold;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Reset output
   // ----------------------------------------------------------------
   // Gating with the raw input gives assertion with a stopped clock
   assign bus_reset_out_n = state_ff[`BRG_OUT_BIT] & power_on_reset_in_n;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Release seen by the machine while parked in the hold state
   sequence s_release;
      state_ff == state_power_on_hold && sync.por_high && sync.clk_valid;
   endsequence

   // The two fixed initialisation steps in order
   sequence s_init_walk;
      state_ff == state_init_first ##1 state_ff == state_init_second;
   endsequence

   // Output level against the raw input and the state register
   a_low_follows_input: assert property (@(posedge clk)
      disable iff (rst)
      !power_on_reset_in_n |-> !bus_reset_out_n)
      else $error("bus reset high while power-on input low");

   // A fall can only be the clear into the hold state
   a_low_only_por: assert property (@(posedge clk)
      disable iff (rst)
      $fell(bus_reset_out_n) |-> state_ff == state_power_on_hold)
      else $error("bus reset low without cause");

   // A rise can only be the clocked step out of the last init state
   a_rise_sync: assert property (@(posedge clk)
      disable iff (rst)
      $rose(bus_reset_out_n) |-> $past(state_ff) == state_init_second &&
                                 state_ff == state_running)
      else $error("bus reset rose without a state edge");

   a_run_bit_only: assert property (@(posedge clk)
      disable iff (rst)
      state_ff[`BRG_OUT_BIT] == (state_ff == state_running))
      else $error("release bit set outside the run state");

   // Input register and state space
   a_sync_once: assert property (@(posedge clk)
      disable iff (rst)
      por_sync_ff == $past(power_on_reset_in_n))
      else $error("power-on input not registered once");

   a_state_legal: assert property (@(posedge clk)
      disable iff (rst)
      state_ff inside {state_power_on_hold, state_init_first,
                       state_init_second, state_running})
      else $error("state register holds an illegal code");

   // Sequencer steps
   a_hold_exit: assert property (@(posedge clk)
      disable iff (rst || !power_on_reset_in_n)
      s_release |=> s_init_walk)
      else $error("hold exit not followed by init states");

   a_hold_wait_cv: assert property (@(posedge clk)
      disable iff (rst || !power_on_reset_in_n)
      state_ff == state_power_on_hold && !sync.clk_valid
      |=> state_ff == state_power_on_hold)
      else $error("hold left without valid clock");

   a_hold_kept: assert property (@(posedge clk)
      disable iff (rst)
      state_ff == state_power_on_hold && !sync.por_high
      |=> state_ff == state_power_on_hold)
      else $error("hold left while input low");

   a_init_first_step: assert property (@(posedge clk)
      disable iff (rst || !power_on_reset_in_n)
      state_ff == state_init_first |=> state_ff == state_init_second)
      else $error("first init state not followed by second");

   a_init_low: assert property (@(posedge clk)
      disable iff (rst)
      state_ff inside {state_init_first, state_init_second}
      |-> !bus_reset_out_n)
      else $error("bus reset high during init");

   // Exact hold length, added cycles included
   a_init_len: assert property (@(posedge clk)
      disable iff (rst || !power_on_reset_in_n)
      state_ff == state_init_first |-> ##INIT_LEN state_ff == state_running)
      else $error("init states of wrong length");

   a_run_high: assert property (@(posedge clk)
      disable iff (rst || !power_on_reset_in_n)
      state_ff == state_running && sync.por_high
      |=> state_ff == state_running && bus_reset_out_n)
      else $error("run state left with input high");

endmodule : brg_bus_reset_gen

`default_nettype wire

// [verif/brg_por_src.sv]
// Power-on reset source and bus arbiter model for the bus reset generator.
// Assumes the bench calls its tasks; levels change once the requested falling edges have passed.
`default_nettype none

module brg_por_src (
   // Bus clock
   input wire logic clk,
   // Bus side
   input wire logic bus_rst_n,
   output logic dflt_grant,
   // Power-on side
   output logic por_n,
   output logic clk_ok
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quiet level: reset held low, clock not yet valid
   initial begin
      por_n = 1'h0;
      clk_ok = 1'h0;
   end
   // Arbiter parks on the default grant while bus reset is low
   always_ff @(posedge clk or negedge bus_rst_n) begin
      if (!bus_rst_n) dflt_grant <= 1'h1;
      else dflt_grant <= 1'h0;
   end
   // Drive both levels after n falling edges
   task automatic drive(input logic p, input logic c, input int n);
      repeat (n) @(negedge clk);
      por_n = p;
      clk_ok = c;
   endtask : drive
endmodule : brg_por_src

`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the bus reset generator.
// Assumes brg_pkg and brg_por_src are compiled first.
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import brg_pkg::*;
   localparam int EXTRA = 3;
   logic clk = 1'h0;
   logic clk_run = 1'h1;
   logic rst = 1'h1;
   wire logic por_n;
   wire logic clk_ok;
   wire logic out_n;
   wire logic dflt_grant;
   int fails = 0;
   int samples_checked = 0;
   int seed = 73428;
   int n;
   longint exp_q[$];
   // Clock; a stopped clock keeps its level
   always #4 clk = clk_run ? ~clk : clk;
   brg_por_src u_src (.clk(clk), .bus_rst_n(out_n),
      .dflt_grant(dflt_grant), .por_n(por_n), .clk_ok(clk_ok));
   brg_bus_reset_gen #(.EXTRA_INIT(EXTRA)) u_dut (.clk(clk), .rst(rst),
      .power_on_reset_in_n(por_n), .clock_valid_in(clk_ok),
      .bus_reset_out_n(out_n));
   task automatic test_done;
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic cmp_t(input string w, input longint e, input longint s);
      samples_checked++;
      if (e !== s) begin
         fails++;
         $display("mismatch %s exp %0d seen %0d", w, e, s);
      end
   endtask : cmp_t
   task automatic cmp_l(input string w, input logic e, input logic s);
      samples_checked++;
      if (e !== s) begin
         fails++;
         $display("mismatch %s exp %b seen %b", w, e, s);
      end
   endtask : cmp_l
   // Note when the output must rise, k edges after this falling edge
   task automatic expect_rise(input int k);
      exp_q.push_back($time + 8 * k - 4);
      for (int i = 0; i < 60 && exp_q.size() > 0; i++) @(negedge clk);
      if (exp_q.size() > 0) begin
         fails++;
         test_done();
      end
   endtask : expect_rise
   // Each release is compared with the oldest note
   initial forever begin
      @(posedge out_n);
      cmp_t("rise", exp_q.size() ? exp_q.pop_front() : -1, $time);
   end
   // Main sequence
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'h0;
      u_src.drive(1'h1, 1'h0, 1);
      repeat (3 + {$random(seed)} % 8) @(negedge clk);
      cmp_l("out_n", 1'h0, out_n);
      u_src.drive(1'h1, 1'h1, 0);
      expect_rise(5 + EXTRA);
      for (int j = 0; j < 6; j++) begin
         repeat (1 + {$random(seed)} % 9) @(negedge clk);
         cmp_l("out_n", 1'h1, out_n);
         cmp_l("dflt_grant", 1'h0, dflt_grant);
         u_src.drive(1'h0, 1'h1, 0);
         #1 cmp_l("out_n", 1'h0, out_n);
         n = 1 + {$random(seed)} % 6;
         repeat (n) @(negedge clk);
         cmp_l("out_n", 1'h0, out_n);
         cmp_l("dflt_grant", 1'h1, dflt_grant);
         if (j == 5) u_src.drive(1'h1, 1'h1, 0);
         else #2 u_src.drive(1'h1, 1'h1, 0);
         if (j != 5) #1 cmp_l("out_n", 1'h0, out_n);
         if (j != 5) @(negedge clk);
         // A release just before a rising edge has used one edge already
         expect_rise((j == 5 ? 4 : 3) + EXTRA);
      end
      @(negedge clk);
      clk_run = 1'h0;
      #20 u_src.drive(1'h0, 1'h1, 0);
      #1 cmp_l("out_n", 1'h0, out_n);
      cmp_l("dflt_grant", 1'h1, dflt_grant);
      #21 clk_run = 1'h1;
      u_src.drive(1'h1, 1'h1, 1);
      expect_rise(4 + EXTRA);
      rst = 1'h1;
      repeat (3) @(negedge clk);
      cmp_l("out_n", 1'h1, out_n);
      rst = 1'h0;
      repeat (4) @(negedge clk);
      cmp_l("out_n", 1'h1, out_n);
      test_done();
   end
endmodule : tb_top

`default_nettype wire
